// ===== pkg/i2c_cfg_pkg.sv
// i2c role, speed and addressing configuration: shared constants and types
// assumes a 32-bit apb register bus and byte addresses
package i2c_cfg_pkg;
	// register byte offsets
	localparam logic [7:0] off_control_config = 8'h00;
	localparam logic [7:0] off_own_target_address = 8'h08;
	localparam logic [7:0] off_unmasked_irq_status = 8'h34;
	localparam logic [7:0] off_master_op_request = 8'h40;
	localparam logic [7:0] off_role_status = 8'h44;
	// control_config layout, bits 10..0
	typedef struct packed {
		logic stop_if_master;
		logic rx_full_hold;
		logic tx_empty_ctrl;
		logic stop_if_addressed;
		logic target_role_off;
		logic restart_allow;
		logic master_wide_addr_select;
		logic slave_wide_addr_select;
		logic [1:0] speed;
		logic controller_role_enable;
	} control_config_s;
	localparam int ctrl_width = 11;
	localparam logic [10:0] ctrl_reset = 11'h0e4;
	localparam logic [1:0] speed_standard = 2'h1;
	localparam logic [1:0] speed_fast = 2'h2;
	localparam logic [9:0] own_addr_reset = 10'h055;
	localparam int abort_bit = 6;
	// master_op_request bit positions
	localparam int op_start_byte = 0;
	localparam int op_high_speed = 1;
	localparam int op_dir_change = 2;
	localparam int op_wide_read = 3;
	localparam int op_repeat_start = 4;
	// role codes on role_status[1:0]
	localparam logic [1:0] role_slave = 2'h1;
	localparam logic [1:0] role_master = 2'h2;
	localparam logic [1:0] role_error = 2'h3;
	localparam logic [4:0] wide_addr_prefix = 5'h1e;
	localparam logic [3:0] bits_per_byte = 4'h8;
endpackage

// ===== rtl/i2c_role_cfg.sv
// apb configuration block of an i2c controller with slave address matching
// assumes pclk at 200 MHz; scl and sda arrive asynchronously from the bus
//
// How it works
// [R1] restart_allow gates master repeated starts
// [R2] target_role_off makes the block master only
// [R3] restart off refuses start byte, hs, turnaround, wide read
// [R4] restart off: repeated start becomes stop plus start
// [R5] refused operation sets abort bit 6 of status
// [R6] wide slave select matches all ten address bits
// [R7] narrow slave select matches low seven bits
// [R8] speed field resets 10, used only as master
// [R9] illegal speed writes are stored as 2
// [R10] controller_role_enable resets 0, enables master
// [R11] software sets both role bits together
// [R12] role bits decode to slave, master or error
// [R13] error role drives nothing and acks nothing
`timescale 1ns/1ps
`default_nettype none
module i2c_role_cfg (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// i2c bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_shift = 4'b0010,
		st_ack = 4'b0100,
		st_skip = 4'b1000
	} slave_state_e;
	// role decode from the two role bits
	function automatic logic [1:0] role_of(input i2c_cfg_pkg::control_config_s c);
		logic [1:0] r;
		r = i2c_cfg_pkg::role_error;
		if (!c.target_role_off && !c.controller_role_enable) begin // [R12]
			r = i2c_cfg_pkg::role_slave;
		end else if (c.target_role_off && c.controller_role_enable) begin
			r = i2c_cfg_pkg::role_master; // [R2]
		end
		return r;
	endfunction
	// address byte comparison for both address widths
	function automatic logic addr_hit(input logic [7:0] b, input logic first,
			input logic wide, input logic [9:0] own);
		logic hit;
		hit = 1'b0;
		if (first && !wide) begin
			hit = (b[7:1] == own[6:0]); // [R7]
		end else if (first) begin
			hit = (b[7:3] == i2c_cfg_pkg::wide_addr_prefix) &&
				(b[2:1] == own[9:8]); // [R6]
		end else begin
			hit = (b == own[7:0]); // [R6]
		end
		return hit;
	endfunction
	// configuration, status and apb response state
	i2c_cfg_pkg::control_config_s ctrl_q, ctrl_d;
	logic [9:0] own_addr_q, own_addr_d;
	logic abort_q, abort_d;
	logic split_q, split_d;
	logic accepted_q, accepted_d;
	logic restart_used_q, restart_used_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [1:0] role, wspeed, speed_eff;
	logic setup, access, mapped, forbidden;
	logic [4:0] op;
	assign role = role_of(ctrl_q);
	assign setup = psel && !penable;
	assign access = psel && penable && pready_q;
	assign mapped = (paddr == i2c_cfg_pkg::off_control_config) ||
		(paddr == i2c_cfg_pkg::off_own_target_address) ||
		(paddr == i2c_cfg_pkg::off_unmasked_irq_status) ||
		(paddr == i2c_cfg_pkg::off_master_op_request) ||
		(paddr == i2c_cfg_pkg::off_role_status);
	assign op = pwdata[4:0];
	assign forbidden = |op[i2c_cfg_pkg::op_wide_read:
		i2c_cfg_pkg::op_start_byte]; // [R3]
	// speed only has meaning in master role
	assign speed_eff = (role == i2c_cfg_pkg::role_master) ?
		ctrl_q.speed : 2'h0; // [R8]
	assign wspeed = (pwdata[2:1] == i2c_cfg_pkg::speed_standard ||
		pwdata[2:1] == i2c_cfg_pkg::speed_fast) ?
		pwdata[2:1] : i2c_cfg_pkg::speed_fast; // [R9]
	// slave-side state, declared here since status reads it
	slave_state_e st_q, st_d;
	logic addressed_q, addressed_d;
	// register file and apb next values
	always_comb begin
		ctrl_d = ctrl_q;
		own_addr_d = own_addr_q;
		abort_d = abort_q;
		split_d = split_q;
		accepted_d = accepted_q;
		restart_used_d = restart_used_q;
		prdata_d = prdata_q;
		pready_d = setup;
		pslverr_d = setup && !mapped;
		if (setup) begin
			prdata_d = 32'h0;
			case (paddr)
				i2c_cfg_pkg::off_control_config: prdata_d[10:0] = ctrl_q;
				i2c_cfg_pkg::off_own_target_address:
					prdata_d[9:0] = own_addr_q;
				i2c_cfg_pkg::off_unmasked_irq_status:
					prdata_d[i2c_cfg_pkg::abort_bit] = abort_q;
				i2c_cfg_pkg::off_role_status:
					prdata_d[7:0] = {addressed_q, restart_used_q, accepted_q,
						split_q, speed_eff, role};
				default: prdata_d = 32'h0;
			endcase
		end
		if (access && pwrite) begin
			case (paddr)
				i2c_cfg_pkg::off_control_config: begin
					ctrl_d = pwdata[10:0]; // [R10]
					ctrl_d.speed = wspeed; // [R9]
				end
				i2c_cfg_pkg::off_own_target_address:
					own_addr_d = pwdata[9:0];
				i2c_cfg_pkg::off_unmasked_irq_status: // write one clears
					abort_d = abort_q && !pwdata[i2c_cfg_pkg::abort_bit];
				i2c_cfg_pkg::off_master_op_request: begin
					// requests only act in master role
					if (role == i2c_cfg_pkg::role_master) begin // [R13]
						if (!ctrl_q.restart_allow && forbidden) begin
							abort_d = 1'b1; // [R5]
							accepted_d = 1'b0; // [R3]
							split_d = 1'b0;
							restart_used_d = 1'b0;
						end else begin
							accepted_d = 1'b1;
							restart_used_d = ctrl_q.restart_allow &&
								op[i2c_cfg_pkg::op_repeat_start]; // [R1]
							split_d = !ctrl_q.restart_allow &&
								op[i2c_cfg_pkg::op_repeat_start]; // [R4]
						end
					end
				end
				default: ;
			endcase
		end
	end
	// register file and apb flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= i2c_cfg_pkg::ctrl_reset; // [R8] [R10]
			own_addr_q <= i2c_cfg_pkg::own_addr_reset;
			abort_q <= 1'b0;
			split_q <= 1'b0;
			accepted_q <= 1'b0;
			restart_used_q <= 1'b0;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			own_addr_q <= own_addr_d;
			abort_q <= abort_d;
			split_q <= split_d;
			accepted_q <= accepted_d;
			restart_used_q <= restart_used_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	// pin synchronisers, three stages each
	logic [2:0] scl_sync_q, sda_sync_q;
	logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl_i};
			sda_sync_q <= {sda_sync_q[1:0], sda_i};
		end
	end
	// filtered levels change once stages two and three agree
	always_comb begin
		scl_f_d = scl_f_q;
		sda_f_d = sda_f_q;
		if (scl_sync_q[1] == scl_sync_q[2]) begin
			scl_f_d = scl_sync_q[2];
		end
		if (sda_sync_q[1] == sda_sync_q[2]) begin
			sda_f_d = sda_sync_q[2];
		end
	end
	// bus edges and start or stop conditions
	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = !scl_f_q && scl_f_d;
	assign scl_fall = scl_f_q && !scl_f_d;
	assign bus_start = scl_f_q && scl_f_d && sda_f_q && !sda_f_d;
	assign bus_stop = scl_f_q && scl_f_d && !sda_f_q && sda_f_d;
	// slave address receiver
	logic [7:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic first_q, first_d, oe_q, oe_d, slave_on;
	assign slave_on = (role == i2c_cfg_pkg::role_slave); // [R2] [R13]
	// address receiver next state
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		first_d = first_q;
		oe_d = oe_q;
		addressed_d = addressed_q;
		case (st_q)
			st_idle, st_skip: ;
			st_shift: begin
				if (scl_rise && cnt_q != i2c_cfg_pkg::bits_per_byte) begin
					sh_d = {sh_q[6:0], sda_f_q};
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && cnt_q == i2c_cfg_pkg::bits_per_byte) begin
					if (addr_hit(sh_q, first_q, ctrl_q.slave_wide_addr_select,
							own_addr_q)) begin
						st_d = st_ack;
						oe_d = 1'b1; // drive ack low
					end else begin
						st_d = st_skip;
					end
				end
			end
			st_ack: begin
				if (scl_fall) begin
					oe_d = 1'b0;
					cnt_d = 4'h0;
					if (first_q && ctrl_q.slave_wide_addr_select) begin
						st_d = st_shift; // second address byte
						first_d = 1'b0;
					end else begin
						st_d = st_skip;
						addressed_d = 1'b1;
					end
				end
			end
			default: st_d = st_idle;
		endcase
		if (bus_start) begin
			st_d = st_shift;
			cnt_d = 4'h0;
			first_d = 1'b1;
			oe_d = 1'b0;
			addressed_d = 1'b0;
		end
		if (bus_stop || !slave_on) begin
			st_d = st_idle;
			oe_d = 1'b0;
			addressed_d = 1'b0;
		end
	end
	// slave receiver flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			st_q <= st_idle;
			sh_q <= 8'h0;
			cnt_q <= 4'h0;
			first_q <= 1'b1;
			oe_q <= 1'b0;
			addressed_q <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
			st_q <= st_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			first_q <= first_d;
			oe_q <= oe_d;
			addressed_q <= addressed_d;
			sda_o <= 1'b0;
		end
	end
	assign sda_oe = oe_q;
endmodule
`default_nettype wire

// ===== verif/i2c_role_cfg_chk.sv
// checker: apb timing, register images, role decode and ack gating
// assumes it is bound to i2c_role_cfg and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module i2c_role_cfg_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// bus
	input wire logic sda_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [10:0] cfg_q;
	logic [2:0] op_q;
	logic [1:0] sl_q;
	logic ab_q, wr, rd, ms, slv, bad, map;
	// completed transfers and role decode of the shadow
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign ms = cfg_q[6] && cfg_q[0];
	assign slv = !cfg_q[6] && !cfg_q[0];
	assign bad = !cfg_q[5] && (pwdata[3:0] != 4'h0);
	assign map = paddr inside {8'h00, 8'h08, 8'h34, 8'h40, 8'h44};
	// shadow of control, abort flag and last operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= i2c_cfg_pkg::ctrl_reset;
			op_q <= 3'h0;
			ab_q <= 1'b0;
			sl_q <= 2'h0;
		end else begin
			sl_q <= {sl_q[0], slv};
			if (wr && paddr == 8'h00) begin
				cfg_q <= pwdata[10:0];
				if (pwdata[2:1] == 2'h0 || pwdata[2:1] == 2'h3)
					cfg_q[2:1] <= i2c_cfg_pkg::speed_fast;
			end
			if (wr && paddr == 8'h34 && pwdata[6])
				ab_q <= 1'b0;
			if (wr && paddr == 8'h40 && ms) begin
				ab_q <= ab_q || bad;
				op_q[1] <= !bad;
				if (!bad)
					op_q <= {cfg_q[5] & pwdata[4], 1'b1, !cfg_q[5] & pwdata[4]};
			end
		end
	end
	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("pready late");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	property p_unmap; pready && !map |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no pslverr");
	property p_cfg; rd && paddr == 8'h00 |-> prdata == {21'h0, cfg_q}; endproperty
	a_cfg: assert property (p_cfg) else $error("control image");
	property p_role; rd && paddr == 8'h44 |-> prdata[1:0] ==
		(ms ? 2'h2 : slv ? 2'h1 : 2'h3); endproperty
	a_role: assert property (p_role) else $error("role code");
	property p_spd; rd && paddr == 8'h44 |-> prdata[3:2] ==
		(ms ? cfg_q[2:1] : 2'h0); endproperty
	a_spd: assert property (p_spd) else $error("speed report");
	property p_abort; rd && paddr == 8'h34 |-> prdata[6] == ab_q; endproperty
	a_abort: assert property (p_abort) else $error("abort flag");
	property p_op; rd && paddr == 8'h44 |-> prdata[5] == op_q[1] &&
		(!op_q[1] || {prdata[6], prdata[4]} == {op_q[2], op_q[0]}); endproperty
	a_op: assert property (p_op) else $error("op status");
	property p_ack; sda_oe |-> slv || sl_q != 2'h0; endproperty
	a_ack: assert property (p_ack) else $error("ack off role");
	// main scenarios reached
	c_ack: cover property ($rose(sda_oe));
	c_abort: cover property (rd && paddr == 8'h34 && prdata[6]);
	c_err: cover property (rd && paddr == 8'h44 && prdata[1:0] == 2'h3);
endmodule
bind i2c_role_cfg i2c_role_cfg_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sda_oe(sda_oe));
`default_nettype wire

// ===== verif/i2c_bus_model.sv
// external i2c master sending address bytes at an 80 ns bit period
// assumes sda has a pull-up; the device drives sda_o while sda_oe is high
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
	// clock and device drive
	input wire logic pclk,
	input wire logic sda_oe,
	input wire logic sda_o,
	// resolved bus levels
	output logic scl,
	output logic sda
);
	logic sda_m = 1'b1;
	// wired-and with pull-up; scl idles high outside frames
	assign sda = sda_m && (!sda_oe || sda_o);
	initial scl = 1'b1;
	// a quarter of the bit period
	task automatic q;
		repeat (4) @(posedge pclk);
	endtask
	// sda falls while scl is high
	task automatic start;
		sda_m <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask
	// eight bits msb first, then sample the ack slot
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_m <= b[i];
			q();
			scl <= 1'b1;
			q();
			q();
			scl <= 1'b0;
			q();
		end
		sda_m <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		ack = !sda;
		q();
		scl <= 1'b0;
		q();
	endtask
	// sda rises while scl is high
	task automatic stop;
		sda_m <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_m <= 1'b1;
		q();
		q();
	endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the i2c role and address configuration block
// assumes the bus model drives scl and the resolved sda level
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, sda_o, sda_oe, ev;
	wire scl, sda;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	i2c_role_cfg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	i2c_bus_model u_bus (.pclk(pclk), .sda_oe(sda_oe), .sda_o(sda_o),
		.scl(scl), .sda(sda));
	// clock and hang guard
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// compare one value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// reset control image and an unmapped address
	task automatic t_reset;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'he4, rv);
		apb(1'b1, 8'h10, 32'h0);
		chk("slverr", 32'h1, {31'h0, ev});
		$display("t_reset done");
	endtask
	// every speed code, each written with one role pair
	task automatic t_cfg;
		logic [1:0] sp;
		for (int k = 0; k < 4; k++) begin
			sp = (k == 1) ? 2'h1 : 2'h2;
			apb(1'b1, 8'h00, {25'h0, k[1], 3'h0, k[1:0], k[0]});
			apb(1'b0, 8'h00, 32'h0);
			chk("ctrl", {25'h0, k[1], 3'h0, sp, k[0]}, rv);
			apb(1'b0, 8'h44, 32'h0);
			chk("role", (k == 0) ? 4'h1 : (k == 3) ? {sp, 2'h2} : 4'h3, rv & 32'hf);
			if (k != 3) begin
				apb(1'b1, 8'h40, 32'h1);
				apb(1'b0, 8'h34, 32'h0);
				chk("idle abort", 32'h0, rv);
			end
		end
		$display("t_cfg done");
	endtask
	// refused, split and restarted operations as master
	task automatic t_ops;
		apb(1'b1, 8'h00, 32'h45);
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, 8'h40, 32'h1 << b);
			apb(1'b0, 8'h34, 32'h0);
			chk("abort", 32'h40, rv);
			apb(1'b1, 8'h34, 32'h40);
		end
		apb(1'b1, 8'h40, 32'h10);
		apb(1'b0, 8'h44, 32'h0);
		chk("split", 32'h3a, rv);
		apb(1'b1, 8'h00, 32'h65);
		apb(1'b1, 8'h40, 32'h18);
		apb(1'b0, 8'h44, 32'h0);
		chk("restart", 32'h6a, rv);
		$display("t_ops done");
	endtask
	// address acks: ctrl, first byte, second byte, expected acks
	task automatic t_slave;
		logic a0, a1;
		logic [31:0] tab [8] = '{32'h04aa0002, 32'h04a80000, 32'h04ab0002,
			32'h0cf4d503, 32'h0cf4d402, 32'h0caa0000, 32'h45aa0000, 32'h44aa0000};
		apb(1'b1, 8'h08, 32'h2d5);
		foreach (tab[i]) begin
			apb(1'b1, 8'h00, {24'h0, tab[i][31:24]});
			u_bus.start();
			u_bus.send(tab[i][23:16], a0);
			a1 = 1'b0;
			if (tab[i][15:8] != 8'h00)
				u_bus.send(tab[i][15:8], a1);
			u_bus.stop();
			chk("ack", tab[i] & 32'h3, {30'h0, a0, a1});
		end
		$display("t_slave done");
	endtask
	// counts and verdict
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cfg();
		t_ops();
		t_slave();
		results();
	end
endmodule
`default_nettype wire
